// file: src/xlm_top.v
// Implementation choice: the APB register port.
`timescale 1ns/100ps
`include "xlm_defines.vh"
module xlm_top #(
  parameter CW = 9
) (
  input  wire        clk_in,
  input  wire        rst_in,
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [11:0] paddr_in,
  input  wire [31:0] pwdata_in,
  output reg         pready_out,
  output reg         pslverr_out,
  output reg  [31:0] prdata_out,
  input  wire        crystal_input_in,
  input  wire        fourth_reference_input_in,
  input  wire        meas_tick_in,
  output reg  [1:0]  los_sts_out,
  output reg         irq_out
);

  // ==========================================================
  // Register storage, one entry per monitor
  reg [7:0] nom   [0:1];
  reg [6:0] accm  [0:1];
  reg [6:0] rejm  [0:1];
  reg [3:0] thr   [0:1];
  reg [1:0] ssel  [0:1];
  reg [4:0] div   [0:1];
  reg [7:0] qual  [0:1];
  reg [1:0] evt   [0:1];
  reg [1:0] mask  [0:1];
  reg [4:0] lcnt  [0:1];
  reg [1:0] en;
  reg [1:0] los_d;
  reg [1:0] last_acc;

  wire [1:0] los;
  wire [1:0] w_acc;
  wire [1:0] w_rej;

  // ==========================================================
  // APB decode
  wire       hit_blk = (paddr_in[11:7] == `XLM_BASE_HI) &&
                       (paddr_in[1:0] == 2'b00); // see (RL1)
  wire       ins     = paddr_in[6];
  wire [3:0] idx     = paddr_in[5:2];
  reg        known;
  reg [31:0] rd;

  always @* begin
    known = 1'b1;
    rd    = 32'h0000_0000;
    if (!hit_blk) begin
      known = 1'b0;
    end else if (idx == `XLM_IDX_NOM) begin // see (RL2)
      rd = {8'h00, nom[ins], 1'b0, accm[ins], 1'b0, rejm[ins]};
    end else if (idx == `XLM_IDX_WIN) begin
      rd = {20'h0_0000, thr[ins], 1'b0, ssel[ins], div[ins]};
    end else if (idx == `XLM_IDX_QUAL) begin
      rd = {24'h00_0000, qual[ins]};
    end else if (idx == `XLM_IDX_CTRL) begin
      rd = {31'h0000_0000, en[ins]};
    end else if (idx == `XLM_IDX_EVT) begin
      rd = {30'h0000_0000, evt[ins]};
    end else if (idx == `XLM_IDX_CEVT) begin
      rd = {27'h000_0000, lcnt[ins]};
    end else if (idx == `XLM_IDX_STS) begin
      rd = {30'h0000_0000, last_acc[ins], los_d[ins]};
    end else if (idx == `XLM_IDX_MASK) begin
      rd = {30'h0000_0000, mask[ins]};
    end else begin
      known = 1'b0;
    end
  end

  // Answer one cycle after the access phase opens; keeps outputs registered
  wire take = psel_in & penable_in & pready_out;
  wire wr   = take & pwrite_in & known;

  always @(posedge clk_in) begin
    if (rst_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else begin
      pready_out  <= psel_in & penable_in & ~pready_out;
      pslverr_out <= psel_in & penable_in & ~pready_out & ~known;
      if (psel_in & penable_in & ~pready_out & ~pwrite_in)
        prdata_out <= rd;
      else
        prdata_out <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // Monitors
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_mon
      wire          rise;
      reg           started;
      reg  [4:0]    ecnt;
      reg  [CW-1:0] pcnt;
      wire          run    = en[g] & (nom[g] != 8'h00); // see (RL4)
      // Divide ratios zero and one both mean one edge per window
      wire [4:0]    dv     = (div[g] < 5'h02) ? 5'h01 : div[g]; // see (RL7)
      wire [CW-1:0] nomx   = {{(CW-8){1'b0}}, nom[g]};
      wire [CW-1:0] hi     = nomx + {{(CW-7){1'b0}}, rejm[g]};
      wire          wend   = started & rise & (ecnt == dv - 5'h01);
      // A stalled input never ends its window; call it rejected once past reach
      wire          tmo    = started & ~wend & (pcnt > hi);
      wire [CW-1:0] dif    = (pcnt >= nomx) ? pcnt - nomx : nomx - pcnt;
      wire          is_acc = dif <= {{(CW-7){1'b0}}, accm[g]}; // see (RL5)
      wire          is_rej = dif >  {{(CW-7){1'b0}}, rejm[g]}; // see (RL6)

      assign w_acc[g] = run & wend & is_acc; // see (RL11)
      assign w_rej[g] = run & ((wend & is_rej) | tmo);

      xlm_sync u_sync (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .d_in     ((g == 0) ? crystal_input_in : fourth_reference_input_in),
        .rise_out (rise)
      );

      always @(posedge clk_in) begin
        if (rst_in || !run) begin
          started <= 1'b0;
          ecnt    <= 5'h00;
          pcnt    <= {CW{1'b0}};
        end else if (!started) begin
          if (rise) begin
            started <= 1'b1;
            ecnt    <= 5'h00;
            pcnt    <= {CW{1'b0}};
          end
        end else if (wend || tmo) begin
          ecnt <= 5'h00;
          pcnt <= {CW{1'b0}}; // see (RL11)
        end else begin
          if (meas_tick_in && pcnt != {CW{1'b1}})
            pcnt <= pcnt + {{(CW-1){1'b0}}, 1'b1}; // see (RL3)
          if (rise)
            ecnt <= ecnt + 5'h01;
        end
      end

      xlm_qual u_qual (
        .clk_in  (clk_in),
        .rst_in  (rst_in),
        .run_in  (run),
        .off_in  (nom[g] == 8'h00),
        .acc_in  (w_acc[g]),
        .rej_in  (w_rej[g]),
        .good_in (qual[g][7:4]),
        .fail_in (qual[g][3:0]),
        .los_out (los[g])
      );
    end
  endgenerate

  // ==========================================================
  // Registers, events and interrupt
  integer i;
  // Per-monitor strobes kept as nets so the register process stays non-blocking
  wire [1:0] sel_w    = {wr & ins, wr & ~ins};
  wire [1:0] los_up_w = los & ~los_d;
  wire [1:0] lmt_w    = {({1'b0, lcnt[1]} > {2'b00, thr[1]}),
                         ({1'b0, lcnt[0]} > {2'b00, thr[0]})};
  wire       irq_nx   = (|(evt[0] & mask[0])) | (|(evt[1] & mask[1]));

  always @(posedge clk_in) begin
    if (rst_in) begin
      en          <= 2'b00;
      los_d       <= 2'b11;
      last_acc    <= 2'b00;
      los_sts_out <= 2'b11;
      irq_out     <= 1'b0;
      for (i = 0; i < 2; i = i + 1) begin
        nom[i]  <= 8'h00;
        accm[i] <= 7'h00;
        rejm[i] <= 7'h00;
        thr[i]  <= 4'h0;
        ssel[i] <= 2'h0;
        div[i]  <= 5'h00;
        qual[i] <= `XLM_QUAL_RST;
        evt[i]  <= 2'h0;
        mask[i] <= 2'h0;
        lcnt[i] <= 5'h00;
      end
    end else begin
      los_d       <= los;
      los_sts_out <= los;
      for (i = 0; i < 2; i = i + 1) begin
        if (w_acc[i] | w_rej[i])
          last_acc[i] <= w_acc[i];
        if (sel_w[i] && idx == `XLM_IDX_NOM) begin
          nom[i]  <= pwdata_in[`XLM_NOM_MSB:`XLM_NOM_LSB];
          accm[i] <= pwdata_in[`XLM_ACC_MSB:`XLM_ACC_LSB];
          rejm[i] <= pwdata_in[`XLM_REJ_MSB:`XLM_REJ_LSB];
        end
        if (sel_w[i] && idx == `XLM_IDX_WIN) begin
          thr[i]  <= pwdata_in[`XLM_THR_MSB:`XLM_THR_LSB];
          ssel[i] <= pwdata_in[`XLM_SSEL_MSB:`XLM_SSEL_LSB];
          div[i]  <= pwdata_in[`XLM_DIV_MSB:`XLM_DIV_LSB];
        end
        if (sel_w[i] && idx == `XLM_IDX_QUAL)
          qual[i] <= pwdata_in[7:0];
        if (sel_w[i] && idx == `XLM_IDX_CTRL)
          en[i] <= pwdata_in[0]; // see (RL10)
        if (sel_w[i] && idx == `XLM_IDX_MASK)
          mask[i] <= pwdata_in[1:0];
        // Counter increments win over a preset in the same cycle
        if (los_up_w[i]) begin
          if (lcnt[i] != `XLM_CNT_MAX)
            lcnt[i] <= lcnt[i] + 5'h01;
        end else if (sel_w[i] && idx == `XLM_IDX_CEVT) begin
          lcnt[i] <= pwdata_in[4:0];
        end
        // Hardware set wins over a write-one clear
        evt[i][`XLM_EVT_LOS] <= los_up_w[i] |
          (evt[i][`XLM_EVT_LOS] & ~(sel_w[i] && idx == `XLM_IDX_EVT &&
                                    pwdata_in[`XLM_EVT_LOS]));
        evt[i][`XLM_EVT_LMT] <= lmt_w[i] | // see (RL9)
          (evt[i][`XLM_EVT_LMT] & ~(sel_w[i] && idx == `XLM_IDX_EVT &&
                                    pwdata_in[`XLM_EVT_LMT]));
      end
      irq_out <= irq_nx;
    end
  end

endmodule // xlm_top

// file: src/xlm_defines.vh
// Summary of operation
// (RL1) Two monitors: crystal input and fourth reference
// (RL2) Decode nominal, window, qual, enable, events, status
// (RL3) Nominal count of measuring clock periods per window
// (RL4) Nominal zero disables monitor, forces loss status
// (RL5) Accept when count within nominal plus/minus margin
// (RL6) Reject when count outside nominal plus/minus margin
// (RL7) Window is one divided monitored period
// (RL8) Good windows qualify, failed windows disqualify clock
// (RL9) Limit event held while loss counter exceeds threshold
// (RL10) Software disables monitor while reprogramming it
// (RL11) Restart count per window, compare at end
`ifndef XLM_DEFINES_VH
`define XLM_DEFINES_VH

// ==========================================================
// Address map
`define XLM_BASE_HI   5'h10
`define XLM_IDX_NOM   4'h0
`define XLM_IDX_WIN   4'h4
`define XLM_IDX_QUAL  4'h6
`define XLM_IDX_CTRL  4'h7
`define XLM_IDX_EVT   4'h8
`define XLM_IDX_CEVT  4'h9
`define XLM_IDX_STS   4'hA
`define XLM_IDX_MASK  4'hB

// ==========================================================
// Field positions
`define XLM_NOM_MSB   23
`define XLM_NOM_LSB   16
`define XLM_ACC_MSB   14
`define XLM_ACC_LSB   8
`define XLM_REJ_MSB   6
`define XLM_REJ_LSB   0
`define XLM_THR_MSB   11
`define XLM_THR_LSB   8
`define XLM_SSEL_MSB  6
`define XLM_SSEL_LSB  5
`define XLM_DIV_MSB   4
`define XLM_DIV_LSB   0
`define XLM_EVT_LOS   0
`define XLM_EVT_LMT   1

// ==========================================================
// Reset values and limits
`define XLM_QUAL_RST  8'h11
`define XLM_CNT_MAX   5'h1F
`define XLM_MEAS_MHZ  216

`endif

// file: src/xlm_sync.v
`timescale 1ns/100ps
module xlm_sync (
  input  wire clk_in,
  input  wire rst_in,
  input  wire d_in,
  output reg  rise_out
);
  reg meta;
  reg stable;
  reg stable_d;

  // ==========================================================
  // Two-stage synchroniser, edge taken after the second stage
  always @(posedge clk_in) begin
    if (rst_in) begin
      meta     <= 1'b0;
      stable   <= 1'b0;
      stable_d <= 1'b0;
      rise_out <= 1'b0;
    end else begin
      meta     <= d_in;
      stable   <= meta;
      stable_d <= stable;
      rise_out <= stable & ~stable_d;
    end
  end
endmodule // xlm_sync

// file: src/xlm_qual.v
`timescale 1ns/100ps
module xlm_qual (
  input  wire       clk_in,
  input  wire       rst_in,
  input  wire       run_in,
  input  wire       off_in,
  input  wire       acc_in,
  input  wire       rej_in,
  input  wire [3:0] good_in,
  input  wire [3:0] fail_in,
  output reg        los_out
);
  reg  [3:0] good_cnt;
  reg  [3:0] fail_cnt;
  // Reserved zero counts behave as one
  wire [3:0] good_lim = (good_in == 4'h0) ? 4'h1 : good_in;
  wire [3:0] fail_lim = (fail_in == 4'h0) ? 4'h1 : fail_in;
  wire [4:0] good_nx  = {1'b0, good_cnt} + 5'h01;
  wire [4:0] fail_nx  = {1'b0, fail_cnt} + 5'h01;

  // ==========================================================
  // Qualification
  always @(posedge clk_in) begin
    if (rst_in) begin
      good_cnt <= 4'h0;
      fail_cnt <= 4'h0;
      los_out  <= 1'b1;
    end else if (!run_in) begin
      good_cnt <= 4'h0;
      fail_cnt <= 4'h0;
      if (off_in)
        los_out <= 1'b1; // see (RL4)
    end else if (acc_in) begin
      fail_cnt <= 4'h0;
      if (good_nx >= {1'b0, good_lim}) begin
        los_out  <= 1'b0; // see (RL8)
        good_cnt <= 4'h0;
      end else begin
        good_cnt <= good_nx[3:0];
      end
    end else if (rej_in) begin
      good_cnt <= 4'h0;
      if (fail_nx >= {1'b0, fail_lim}) begin
        los_out  <= 1'b1; // see (RL8)
        fail_cnt <= 4'h0;
      end else begin
        fail_cnt <= fail_nx[3:0];
      end
    end
  end
endmodule // xlm_qual

// file: dv/xlm_clk_src.sv
`timescale 1ns/100ps
module xlm_clk_src (
  input  wire logic       clk_in,
  input  wire logic [7:0] half_in,
  output logic            clk_out
);
  logic [7:0] cnt;
  initial begin
    cnt = 8'h00;
    clk_out = 1'b0;
  end
  // ====================
  // Monitored clock
  // Half period zero stops it low, the way a dead crystal stops
  always @(posedge clk_in) begin
    if (half_in == 8'h00) begin
      cnt <= 8'h00;
      clk_out <= 1'b0;
    end else if (cnt + 8'h01 >= half_in) begin
      cnt <= 8'h00;
      clk_out <= ~clk_out;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule // xlm_clk_src

// file: dv/xlm_properties.sv
`timescale 1ns/100ps
module xlm_props (
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic [31:0] prdata_out,
  input wire logic        crystal_input_in,
  input wire logic [1:0]  los_sts_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic [7:0] since_rise;
  logic       xin_d;
  always @(posedge clk_in) begin
    xin_d <= crystal_input_in;
    if (rst_in) since_rise <= 8'hFF;
    else if (crystal_input_in && !xin_d) since_rise <= 8'h00;
    else if (since_rise != 8'hFF) since_rise <= since_rise + 8'h01;
  end
  // ====================
  // Bus
  sequence s_acc;
    psel_in && penable_in && !pready_out;
  endsequence
  sequence s_bad;
    s_acc ##0 (paddr_in[11:7] != 5'h10 || paddr_in[1:0] != 2'h0);
  endsequence
  one_wait_a: assert property (s_acc |=> pready_out ##1 !pready_out)
    else $error("ready not one cycle after access");
  bad_addr_err_a: assert property (s_bad |=> pslverr_out && prdata_out == 32'h0000_0000)
    else $error("unmapped access not refused");
  good_addr_ok_a: assert property (s_acc ##0 (paddr_in[11:7] == 5'h10 && paddr_in[1:0] == 2'h0
    && paddr_in[5:2] inside {4'h0, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB}) |=> !pslverr_out)
    else $error("mapped access refused");
  err_has_ready_a: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  ready_has_req_a: assert property (pready_out |-> psel_in && penable_in)
    else $error("ready without access");
  rdata_quiet_a: assert property (!pready_out || pwrite_in |-> prdata_out == 32'h0000_0000)
    else $error("read data outside read");
  // ====================
  // Monitor
  reset_lost_a: assert property ($fell(rst_in) |-> los_sts_out == 2'b11)
    else $error("loss status not set after reset");
  // Qualifying only happens as a monitored edge closes a window
  clear_near_edge_a: assert property ($fell(los_sts_out[0]) |-> since_rise <= 8'h0A)
    else $error("loss cleared away from window end");
endmodule // xlm_props
bind xlm_top xlm_props u_props (
  .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .prdata_out(prdata_out),
  .crystal_input_in(crystal_input_in), .los_sts_out(los_sts_out)
);

// file: dv/testbench.sv
`timescale 1ns/100ps
`include "xlm_defines.vh"
module testbench;
  logic        clk, rst, psel, penable, pwrite, tick, pready, pslverr, irq, crystal_input, fourth_reference_input, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [1:0]  los;
  logic [7:0]  half0, half1;
  int          failures, n_tests;
  xlm_top dut (
    .clk_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready), .pslverr_out(pslverr),
    .prdata_out(prdata), .crystal_input_in(crystal_input), .fourth_reference_input_in(fourth_reference_input),
    .meas_tick_in(tick), .los_sts_out(los), .irq_out(irq)
  );
  xlm_clk_src u_xin (.clk_in(clk), .half_in(half0), .clk_out(crystal_input));
  xlm_clk_src u_fourth_reference_input (.clk_in(clk), .half_in(half1), .clk_out(fourth_reference_input));
  always #4 clk = ~clk;
  // ====================
  // Helpers
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Idle cycle after each transfer keeps psel from being driven twice per step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      failures++;
      stop_test();
    end
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(q, exp);
  endtask
  function automatic logic [11:0] ad(input logic m, input logic [3:0] idx);
    return {`XLM_BASE_HI, m, idx, 2'b00};
  endfunction
  task automatic wait_los(input int b, input logic v);
    int n;
    n = 0;
    while (los[b] !== v && n < 600) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, los[b]}, {31'h0, v});
    if (n >= 600) stop_test();
  endtask
  // ====================
  // Scenarios
  task automatic t_reset;
    rd(ad(0, `XLM_IDX_NOM), 32'h0000_0000);
    rd(ad(1, `XLM_IDX_QUAL), 32'h0000_0011);
    chk({30'h0, los}, 32'h0000_0003);
  endtask
  task automatic t_bad;
    rd(12'h000, 32'h0000_0000);
    chk({31'h0, e}, 32'h0000_0001);
    wr(ad(0, 4'h5), 32'hFFFF_FFFF);
    chk({31'h0, e}, 32'h0000_0001);
  endtask
  task automatic t_qual;
    wr(ad(0, `XLM_IDX_NOM), 32'h0014_0204);
    wr(ad(0, `XLM_IDX_WIN), 32'h0000_0001);
    wr(ad(0, `XLM_IDX_QUAL), 32'h0000_0021);
    wr(ad(0, `XLM_IDX_MASK), 32'h0000_0001);
    half0 <= 8'h0A;
    wr(ad(0, `XLM_IDX_CTRL), 32'h0000_0001);
    rd(ad(0, `XLM_IDX_NOM), 32'h0014_0204);
    wait_los(0, 1'b0);
    rd(ad(0, `XLM_IDX_STS), 32'h0000_0002);
  endtask
  task automatic t_rej;
    half0 <= 8'h0F;
    wait_los(0, 1'b1);
    rd(ad(0, `XLM_IDX_EVT), 32'h0000_0003);
    chk({31'h0, irq}, 32'h0000_0001);
    rd(ad(0, `XLM_IDX_CEVT), 32'h0000_0001);
    wr(ad(0, `XLM_IDX_EVT), 32'h0000_0001);
    rd(ad(0, `XLM_IDX_EVT), 32'h0000_0002);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(ad(0, `XLM_IDX_CEVT), 32'h0000_0000);
    wr(ad(0, `XLM_IDX_EVT), 32'h0000_0002);
    rd(ad(0, `XLM_IDX_EVT), 32'h0000_0000);
  endtask
  task automatic t_nom0;
    wr(ad(1, `XLM_IDX_NOM), 32'h0014_0204);
    wr(ad(1, `XLM_IDX_WIN), 32'h0000_0002);
    half1 <= 8'h05;
    wr(ad(1, `XLM_IDX_CTRL), 32'h0000_0001);
    wait_los(1, 1'b0);
    wr(ad(1, `XLM_IDX_CTRL), 32'h0000_0000);
    wr(ad(1, `XLM_IDX_NOM), 32'h0000_0204);
    wr(ad(1, `XLM_IDX_CTRL), 32'h0000_0001);
    // Last window before the disable was accepted, so bit 1 stays set
    rd(ad(1, `XLM_IDX_STS), 32'h0000_0003);
    chk({31'h0, los[1]}, 32'h0000_0001);
  endtask
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    tick = 1'b1;
    half0 = 8'h00;
    half1 = 8'h00;
    failures = 0;
    n_tests = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_bad();
    t_qual();
    t_rej();
    t_nom0();
    stop_test();
  end
endmodule // testbench
